// ### rtl/stc_consts.svh
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// Register byte addresses on the APB.
`define STC_OFF_CTRL      12'h000
`define STC_OFF_LOW       12'h004
`define STC_OFF_HIGH      12'h008
`define STC_OFF_FLAG      12'h00C
`define STC_OFF_IRQEN     12'h010

// Field positions inside count_control.
`define STC_CTRL_WIDE     7
`define STC_CTRL_PS_HI    5
`define STC_CTRL_PS_LO    4
`define STC_CTRL_OSCEN    3
`define STC_CTRL_BYPASS   2
`define STC_CTRL_SRC      1
`define STC_CTRL_RUN      0

// Reset values and the mask of implemented control bits.
`define STC_CTRL_RST      8'h00
`define STC_CTRL_MASK     8'hBF
`define STC_COUNT_RST     16'h0000
`define STC_COUNT_MAX     16'hFFFF

// Timing: pclk period and the instruction cycle as a count of oscillator periods.
`define STC_PCLK_NS       25
`define STC_INSTR_PERIODS 4

`endif

// ### rtl/stc_pkg.sv
package stc_pkg;

  // One byte of the count and a full count word.
  typedef logic [7:0]  stc_byte_t;
  typedef logic [15:0] stc_count_t;

  // Register selected by an APB address.
  typedef enum logic [5:0] {
    STC_SEL_NONE  = 6'h01,
    STC_SEL_CTRL  = 6'h02,
    STC_SEL_LOW   = 6'h04,
    STC_SEL_HIGH  = 6'h08,
    STC_SEL_FLAG  = 6'h10,
    STC_SEL_IRQEN = 6'h20
  } stc_sel_e;

  // Whole state of the timer block except the prescaler.
  typedef struct packed {
    stc_byte_t  ctrl;       // count_control register.
    stc_count_t count;      // Live count, high byte and low byte.
    stc_byte_t  hbuf;       // High byte buffer used in wide access mode.
    logic       ovf_flag;   // overflow_flag.
    logic       ovf_ie;     // overflow_irq_enable.
    logic       irq;        // Interrupt request output.
    logic       pready;     // APB ready.
    logic       pslverr;    // APB error.
    logic [31:0] prdata;    // APB read data.
    logic [2:0] sync1;      // First synchroniser stage of the pins.
    logic [2:0] sync2;      // Second synchroniser stage of the pins.
    logic       src_prev;   // Previous level of the selected external source.
    logic       pend;       // External edge waiting for an instruction cycle.
    logic [1:0] div;        // Instruction cycle divider.
    logic       instr_en;   // One pulse per instruction cycle.
    logic       tick;       // Source tick towards the prescaler.
    logic       presc_clr;  // Clears the prescaler.
    logic [1:0] pin_o;      // Pin output values.
    logic [1:0] pin_oe;     // Pin output enables.
    logic [1:0] port_rd;    // Pin values seen by port reads.
    logic       osc_en;     // Oscillator enable output.
  } stc_state_s;

  // State of the prescaler.
  typedef struct packed {
    logic [2:0] cnt;        // Divide counter.
    logic       tick;       // Divided tick.
  } stc_presc_s;

endpackage

// ### rtl/stc_prescale.sv
`timescale 1ns/10ps
`include "stc_consts.svh"

// Input prescaler: passes one of every 1, 2, 4 or 8 source ticks.
module stc_prescale
  import stc_pkg::*;
#(
  parameter int CNT_W = 3   // Width of the divide counter.
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick_in,   // Source tick, one cycle.
  input  wire logic       clr,       // Restarts the division.
  input  wire logic [1:0] ratio,     // input_prescale_select.
  output logic            tick_out   // Divided tick, registered.
);

  stc_presc_s st_r;   // Current state.
  stc_presc_s st_nxt; // Next state.

  // Turns the ratio code into the mask of counter bits that must be all ones.
  function automatic logic [2:0] ratio_mask(input logic [1:0] code);
    unique case (code)
      2'h3:    ratio_mask = 3'h7; // Divide by 8.
      2'h2:    ratio_mask = 3'h3; // Divide by 4.
      2'h1:    ratio_mask = 3'h1; // Divide by 2.
      default: ratio_mask = 3'h0; // No division.
    endcase
  endfunction

  // Counts source ticks and passes the one that completes the ratio.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (clr) begin
      st_nxt.cnt = 3'h0; // A low byte write restarts the division.
    end else if (tick_in) begin
      st_nxt.tick = ((st_r.cnt & ratio_mask(ratio)) == ratio_mask(ratio));
      st_nxt.cnt  = 3'(st_r.cnt + 3'h1);
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

endmodule

// ### rtl/stc_timer.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "stc_consts.svh"

// Operation
// - 16-bit count in two bytes, overflow on wrap.
// - Both count bytes readable and writable.
// - Control bit 7 selects wide access.
// - Control bit 6 always reads zero.
// - Bits 5-4 select prescale 1,2,4,8.
// - Bit 3 enables or shuts low-power oscillator.
// - Bit 2 set bypasses external clock synchronisation.
// - Internal source ignores the synchronisation bit.
// - Bit 1 selects external pin or instruction clock.
// - Bit 0 runs counter; cleared holds value.
// - Internal source counts every instruction cycle.
// - External source counts rising edges of pin/oscillator.
// - Oscillator enabled forces pins input, reads zero.
// - Compare unit triggers clear the count.
// - Overflow latches flag; interrupt only if enabled.
// - Wide mode low read copies high byte.
// - Wide mode high write buffers; low write loads.
// - Counter write beats a trigger reset.
module stc_timer
  import stc_pkg::*;
#(
  parameter int ADDR_W = 12  // APB address width.
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              compare_unit_one,   // Special event trigger, one cycle.
  input  wire logic              compare_unit_two,   // Special event trigger, one cycle.
  input  wire logic              ext_count_clock_pin,// Pin 0 level, also the external clock.
  input  wire logic              osc_input_pin,      // Pin 1 level.
  input  wire logic              osc_clock_in,       // Output of the low-power oscillator.
  input  wire logic [1:0]        port_c_direction,   // 1 means input, per pin.
  input  wire logic [1:0]        port_c_latch,       // Port output data per pin.
  output logic [1:0]             pin_o,              // Pin drive values.
  output logic [1:0]             pin_oe,             // Pin drive enables, high drives.
  output logic [1:0]             port_c_read,        // Pin levels seen by port reads.
  output logic                   osc_enable,         // Powers the low-power oscillator.
  output logic                   overflow_irq        // Interrupt request.
);

  localparam int INSTR_CYCLES = `STC_INSTR_PERIODS; // Oscillator periods per instruction.

  stc_state_s st_r;    // Current state.
  stc_state_s st_nxt;  // Next state.
  logic       presc_tick; // Divided count tick from the prescaler.

  // Maps an address to the register it selects.
  function automatic stc_sel_e addr_decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      `STC_OFF_CTRL:  addr_decode = STC_SEL_CTRL;
      `STC_OFF_LOW:   addr_decode = STC_SEL_LOW;
      `STC_OFF_HIGH:  addr_decode = STC_SEL_HIGH;
      `STC_OFF_FLAG:  addr_decode = STC_SEL_FLAG;
      `STC_OFF_IRQEN: addr_decode = STC_SEL_IRQEN;
      default:        addr_decode = STC_SEL_NONE;
    endcase
  endfunction

  // The prescaler divides the source ticks.
  stc_prescale #(
    .CNT_W (3)
  ) u_prescale (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (st_r.tick),
    .clr      (st_r.presc_clr),
    .ratio    (st_r.ctrl[`STC_CTRL_PS_HI:`STC_CTRL_PS_LO]),
    .tick_out (presc_tick)
  );

  // Next state of the whole block.
  always_comb begin
    stc_sel_e   sel;        // Register addressed by the bus.
    logic       setup;      // First cycle of the access phase.
    logic       done;       // Completing edge of a transfer.
    logic       wr_low;     // Completed write to the low byte.
    logic       wr_high;    // Completed write to the high byte.
    logic       wide;       // Wide access mode.
    logic       src_lvl;    // Level of the selected external source.
    logic       src_rise;   // Rising edge of that source.
    logic       cnt_inc;    // The count advances this cycle.
    logic       trig;       // A compare unit asks for a clear.
    logic       ovf;        // The count wraps this cycle.
    stc_count_t inc_val;    // Count plus one.
    sel      = addr_decode(paddr);
    setup    = psel && penable && !st_r.pready;
    done     = psel && penable && st_r.pready;
    wide     = st_r.ctrl[`STC_CTRL_WIDE];
    wr_low   = done && pwrite && (sel == STC_SEL_LOW);
    wr_high  = done && pwrite && (sel == STC_SEL_HIGH);
    st_nxt   = st_r;

    // Pins pass two flip-flops before anything looks at them.
    st_nxt.sync1 = {osc_clock_in, osc_input_pin, ext_count_clock_pin};
    st_nxt.sync2 = st_r.sync1;

    // The instruction clock is one pulse every four oscillator periods.
    st_nxt.div      = 2'(st_r.div + 2'h1);
    st_nxt.instr_en = (st_r.div == 2'(INSTR_CYCLES - 1));

    // The oscillator output replaces the pin when the oscillator runs.
    src_lvl         = st_r.ctrl[`STC_CTRL_OSCEN] ? st_r.sync2[2] : st_r.sync2[0];
    src_rise        = src_lvl && !st_r.src_prev;
    st_nxt.src_prev = src_lvl;

    // Chooses the tick that feeds the prescaler.
    st_nxt.tick = 1'b0;
    st_nxt.pend = st_r.pend;
    if (!st_r.ctrl[`STC_CTRL_SRC]) begin
      // Internal source: the synchronisation bit plays no part.
      st_nxt.tick = st_r.instr_en;
      st_nxt.pend = 1'b0;
    end else if (st_r.ctrl[`STC_CTRL_BYPASS]) begin
      // Unsynchronised: each edge counts as soon as it is seen.
      st_nxt.tick = src_rise;
      st_nxt.pend = 1'b0;
    end else begin
      // Synchronised: an edge waits for the next instruction cycle.
      if (st_r.instr_en) begin
        st_nxt.tick = st_r.pend || src_rise;
        st_nxt.pend = 1'b0;
      end else if (src_rise) begin
        st_nxt.pend = 1'b1;
      end
    end
    if (!st_r.ctrl[`STC_CTRL_RUN]) begin
      st_nxt.tick = 1'b0;
    end

    // Advance and wrap of the count.
    cnt_inc = presc_tick && st_r.ctrl[`STC_CTRL_RUN];
    inc_val = 16'(st_r.count + 16'h0001);
    ovf     = cnt_inc && (st_r.count == `STC_COUNT_MAX);
    trig    = compare_unit_one || compare_unit_two;
    if (cnt_inc) begin
      st_nxt.count = inc_val;
    end
    if (trig) begin
      st_nxt.count = `STC_COUNT_RST;
    end

    // Only low byte writes restart the prescaler.
    st_nxt.presc_clr = wr_low;

    // APB: ready on the second access cycle, data prepared in the first.
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup && (sel == STC_SEL_NONE);
    if (setup) begin
      unique case (sel)
        STC_SEL_CTRL:  st_nxt.prdata = {24'h000000, st_r.ctrl & `STC_CTRL_MASK};
        STC_SEL_LOW:   st_nxt.prdata = {24'h000000, st_r.count[7:0]};
        STC_SEL_HIGH:  st_nxt.prdata = {24'h000000, wide ? st_r.hbuf : st_r.count[15:8]};
        STC_SEL_FLAG:  st_nxt.prdata = {31'h00000000, st_r.ovf_flag};
        STC_SEL_IRQEN: st_nxt.prdata = {31'h00000000, st_r.ovf_ie};
        default:       st_nxt.prdata = 32'h00000000;
      endcase
    end

    // Effects of a completed transfer.
    if (done && !pwrite && (sel == STC_SEL_LOW) && wide) begin
      st_nxt.hbuf = st_r.count[15:8];
    end
    if (done && pwrite) begin
      unique case (sel)
        STC_SEL_CTRL: begin
          st_nxt.ctrl = pwdata[7:0] & `STC_CTRL_MASK;
        end
        STC_SEL_LOW: begin
          // A write beats both the increment and a trigger.
          if (wide) begin
            st_nxt.count = {st_r.hbuf, pwdata[7:0]};
          end else begin
            st_nxt.count = {st_r.count[15:8], pwdata[7:0]};
          end
        end
        STC_SEL_HIGH: begin
          if (wide) begin
            st_nxt.hbuf = pwdata[7:0];
          end else begin
            st_nxt.count = {pwdata[7:0], st_r.count[7:0]};
          end
        end
        STC_SEL_FLAG: begin
          // Writing one clears the flag.
          if (pwdata[0]) begin
            st_nxt.ovf_flag = 1'b0;
          end
        end
        STC_SEL_IRQEN: begin
          st_nxt.ovf_ie = pwdata[0];
        end
        default: begin
          st_nxt.ovf_ie = st_r.ovf_ie; // Unmapped writes change nothing.
        end
      endcase
    end

    // A wrap sets the flag even if software clears it in the same cycle.
    if (ovf) begin
      st_nxt.ovf_flag = 1'b1;
    end
    st_nxt.irq = st_nxt.ovf_flag && st_nxt.ovf_ie;

    // Pin control: the running oscillator takes both pins as inputs.
    st_nxt.osc_en = st_nxt.ctrl[`STC_CTRL_OSCEN];
    st_nxt.pin_o  = port_c_latch;
    // Pins follow the same control value as the oscillator enable, so both change together.
    if (st_nxt.ctrl[`STC_CTRL_OSCEN]) begin
      st_nxt.pin_oe  = 2'h0;
      st_nxt.port_rd = 2'h0;
    end else begin
      st_nxt.pin_oe  = ~port_c_direction;
      st_nxt.port_rd = st_r.sync2[1:0];
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.ctrl <= `STC_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output comes straight from the state register.
  assign pready       = st_r.pready;
  assign pslverr      = st_r.pslverr;
  assign prdata       = st_r.prdata;
  assign pin_o        = st_r.pin_o;
  assign pin_oe       = st_r.pin_oe;
  assign port_c_read  = st_r.port_rd;
  assign osc_enable   = st_r.osc_en;
  assign overflow_irq = st_r.irq;

endmodule

// ### tb/stc_timer_asserts.sv
`timescale 1ns/10ps
`include "stc_consts.svh"

// Port-level checks of the timer: bus handshake, read data and pin control.
module stc_timer_asserts
  import stc_pkg::*;
#(
  parameter int ADDR_W = 12  // Bus address width, as in the design.
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  input wire logic [1:0]        port_c_latch,
  input wire logic [1:0]        pin_o,
  input wire logic [1:0]        pin_oe,
  input wire logic [1:0]        port_c_read,
  input wire logic              osc_enable
);
  // All checks run on the bus clock and rest while reset is low.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_one_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  idle_ready_a: assert property (!psel |-> !pready) else $error("ready without select");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
  bit6_zero_a: assert property (pready && !pwrite && paddr == `STC_OFF_CTRL |-> !prdata[6])
    else $error("control bit 6 read as one");
  osc_follow_a: assert property (pready && pwrite && !pslverr && paddr == `STC_OFF_CTRL
    |-> ##2 osc_enable == $past(pwdata[`STC_CTRL_OSCEN], 2)) else $error("oscillator enable wrong");
  osc_pins_a: assert property (osc_enable |-> pin_oe == 2'b00 && port_c_read == 2'b00)
    else $error("pins not inputs with oscillator");
  latch_out_a: assert property ($past(presetn) |-> pin_o == $past(port_c_latch))
    else $error("pin value not the latch");
endmodule

bind stc_timer stc_timer_asserts #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .port_c_latch(port_c_latch), .pin_o(pin_o), .pin_oe(pin_oe), .port_c_read(port_c_read),
  .osc_enable(osc_enable));

// ### tb/stc_clk_src.sv
`timescale 1ns/10ps

// Far-side clock source: a burst of n slow rising edges on the pin, or on the oscillator when powered.
module stc_clk_src #(
  parameter int HALF = 8  // Half period in bus cycles, slow enough for the synchroniser.
) (
  input  wire logic       pclk,
  input  wire logic       start,
  input  wire logic [7:0] n,
  input  wire logic       osc_on,
  output logic            ext_pin,
  output logic            osc_out,
  output logic            busy
);
  logic clk_r = 1'b0;  // Source level, low between bursts.
  int   left  = 0;     // Half periods still to run.
  int   ph    = 0;     // Bus cycles within a half period.

  // Toggles 2n times so the burst ends low and then stands still.
  always @(posedge pclk) begin
    if (start) begin
      left <= 2 * n;
      ph   <= 0;
    end else if (left > 0) begin
      if (ph == HALF - 1) begin
        ph    <= 0;
        left  <= left - 1;
        clk_r <= ~clk_r;
      end else begin
        ph <= ph + 1;
      end
    end
  end

  // The oscillator only swings while powered; otherwise the pin carries the clock.
  assign osc_out = osc_on & clk_r;
  assign ext_pin = osc_on ? 1'b0 : clk_r;
  assign busy    = (left != 0);
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "stc_consts.svh"

// Self-checking bench of the timer through its bus, pins and triggers.
module testbench;
  import stc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, err, trig1 = 0, trig2 = 0, start = 0, osc_en, irq, ext_pin, osc_out, busy;
  logic [1:0]  dir = 2'b11, lat = 2'b00, pin_o, pin_oe, prd;
  logic [7:0]  n = 8'h00;
  int          bad_count = 0, checks = 0;

  stc_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .compare_unit_one(trig1), .compare_unit_two(trig2), .ext_count_clock_pin(ext_pin),
    .osc_input_pin(1'b0), .osc_clock_in(osc_out), .port_c_direction(dir), .port_c_latch(lat),
    .pin_o(pin_o), .pin_oe(pin_oe), .port_c_read(prd), .osc_enable(osc_en), .overflow_irq(irq));
  stc_clk_src src_u (.pclk(pclk), .start(start), .n(n), .osc_on(osc_en), .ext_pin(ext_pin),
    .osc_out(osc_out), .busy(busy));

  // Clock at 40 MHz.
  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // Compares one value and counts it.
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer; holds the request until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) bad_count++;
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // Resets, control bits and an unmapped place.
  task t_regs;
    apb(0, `STC_OFF_CTRL, 0); chk("ctrl_rst", 32'h0, q);
    apb(0, `STC_OFF_HIGH, 0); chk("high_rst", 32'h0, q);
    apb(1, `STC_OFF_CTRL, 32'hF6); apb(0, `STC_OFF_CTRL, 0); chk("ctrl_rw", 32'hB6, q);
    apb(0, 12'h020, 0); chk("unmapped", 1, err);
    $display("t_regs done");
  endtask

  // Byte access reaches the live bytes; wide access goes through the buffer.
  task t_access;
    apb(1, `STC_OFF_CTRL, 0); apb(1, `STC_OFF_HIGH, 8'h12); apb(1, `STC_OFF_LOW, 8'h34);
    apb(0, `STC_OFF_HIGH, 0); chk("byte_hi", 32'h12, q);
    apb(1, `STC_OFF_CTRL, 32'h80); apb(1, `STC_OFF_HIGH, 8'hAB);
    apb(1, `STC_OFF_CTRL, 0); apb(0, `STC_OFF_HIGH, 0); chk("buf_only", 32'h12, q);
    apb(1, `STC_OFF_CTRL, 32'h80); apb(1, `STC_OFF_HIGH, 8'hAB); apb(1, `STC_OFF_LOW, 8'hCD);
    apb(0, `STC_OFF_LOW, 0); apb(1, `STC_OFF_CTRL, 0); apb(1, `STC_OFF_HIGH, 8'h66);
    apb(1, `STC_OFF_CTRL, 32'h80); apb(0, `STC_OFF_HIGH, 0); chk("wide_rd", 32'hAB, q);
    $display("t_access done");
  endtask

  // Internal source through each prescale ratio, with a start and a stop.
  task t_prescale;
    logic [31:0] prev;
    for (int p = 0; p < 4; p++) begin
      apb(1, `STC_OFF_CTRL, 0); apb(1, `STC_OFF_LOW, 0);
      apb(1, `STC_OFF_CTRL, (p << 4) | 32'h5);
      repeat ((32 << p) - 3) @(posedge pclk);
      apb(1, `STC_OFF_CTRL, p << 4); apb(0, `STC_OFF_LOW, 0);
      chk("ps_count", 1, q >= 7 && q <= 9);
      prev = q;
      repeat (40) @(posedge pclk);
      apb(0, `STC_OFF_LOW, 0); chk("held", prev, q);
    end
    $display("t_prescale done");
  endtask

  // Wrap from the top, flag, mask and clear.
  task t_overflow;
    apb(1, `STC_OFF_CTRL, 0); apb(1, `STC_OFF_HIGH, 8'hFF); apb(1, `STC_OFF_LOW, 8'hFF);
    apb(1, `STC_OFF_CTRL, 1); repeat (30) @(posedge pclk); apb(1, `STC_OFF_CTRL, 0);
    apb(0, `STC_OFF_FLAG, 0); chk("flag", 32'h1, q);
    chk("masked", 0, irq);
    apb(0, `STC_OFF_HIGH, 0); chk("wrap_hi", 32'h0, q);
    apb(0, `STC_OFF_LOW, 0); chk("goes_on", 1, q != 0);
    apb(1, `STC_OFF_IRQEN, 1); repeat (2) @(posedge pclk); chk("irq", 1, irq);
    apb(1, `STC_OFF_FLAG, 1); apb(0, `STC_OFF_FLAG, 0); chk("cleared", 32'h0, q);
    repeat (2) @(posedge pclk); chk("irq_off", 0, irq);
    $display("t_overflow done");
  endtask

  // Pin edges, synchronised and not, then the oscillator with pins forced to inputs.
  task t_ext;
    logic [31:0] mode [3];
    mode = '{32'h03, 32'h07, 32'h0B};
    dir <= 2'b00;
    for (int m = 0; m < 3; m++) begin
      apb(1, `STC_OFF_CTRL, 0); apb(1, `STC_OFF_LOW, 0); apb(1, `STC_OFF_CTRL, mode[m]);
      repeat (3) @(posedge pclk);
      n <= 8'd5 + m; start <= 1; @(posedge pclk); start <= 0;
      @(posedge pclk);
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge pclk);
      if (m == 2) chk("osc_pins", 32'h0, {pin_oe, prd});
      repeat (12) @(posedge pclk);
      apb(0, `STC_OFF_LOW, 0); chk("ext_cnt", 5 + m, q);
    end
    apb(1, `STC_OFF_CTRL, 0); repeat (3) @(posedge pclk); chk("pins_out", 2'b11, pin_oe);
    lat <= 2'b10; repeat (3) @(posedge pclk); chk("pin_val", 2'b10, pin_o);
    $display("t_ext done");
  endtask

  // Both compare triggers clear a held count.
  task t_trig;
    for (int u = 0; u < 2; u++) begin
      apb(1, `STC_OFF_HIGH, 8'h12); apb(1, `STC_OFF_LOW, 8'h34);
      @(posedge pclk); trig1 <= (u == 0); trig2 <= (u == 1);
      @(posedge pclk); trig1 <= 0; trig2 <= 0;
      apb(0, `STC_OFF_HIGH, 0); chk("trig_hi", 32'h0, q);
      apb(0, `STC_OFF_LOW, 0); chk("trig_lo", 32'h0, q);
    end
    $display("t_trig done");
  endtask

  // Prints the counts and the verdict, then stops.
  task summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence after two cycles of reset.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_regs; t_access; t_prescale; t_overflow; t_ext; t_trig;
    summarize;
  end

  // Cuts a hang short well beyond the expected run.
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    summarize;
  end
endmodule
